// ### ddr_init_defs.svh
// timing counts, command encodings and mode bit positions for the power-up sequencer
`ifndef DDR_INIT_DEFS_SVH
`define DDR_INIT_DEFS_SVH
`define CLK_PERIOD_PS 25000
`define POWERUP_WAIT_US 200
`define POWERUP_WAIT_CYC ((`POWERUP_WAIT_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PRECHARGE_WAIT_NS 20
`define PRECHARGE_WAIT_CYC ((`PRECHARGE_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MODE_SET_WAIT_NS 15
`define MODE_SET_WAIT_CYC ((`MODE_SET_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REFRESH_CYCLE_WAIT_NS 75
`define REFRESH_CYCLE_WAIT_CYC ((`REFRESH_CYCLE_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DLL_LOCK_CYC 200
// command pins {cs_n, ras_n, cas_n, we_n}
`define CMD_DESELECT 4'h8
`define CMD_NOP 4'h7
`define CMD_PRECHARGE 4'h2
`define CMD_REFRESH 4'h1
`define CMD_LOAD_MODE 4'h0
`define A10_BIT 10
`define DLL_RESET_BIT 8
`define DLL_DISABLE_BIT 0
`define DRIVE_STRENGTH_BIT 1
`define BA_BASE_MODE 2'h0
`define BA_EXT_MODE 2'h1
// software register offsets
`define REG_CTRL 4'h0
`define REG_MODE 4'h1
`define REG_STATUS 4'h2
`define CTRL_START 0
`define CTRL_REDUCED_DRIVE 1
`define CTRL_CLEAR_DLL 2
`define CTRL_REFRESH_EARLY 3
`endif

// ### ddr_init_pkg.sv
// types shared by the power-up sequencer
package ddr_init_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_POWER_WAIT, ST_FIRST_NOP, ST_PRE1, ST_EMR, ST_MR, ST_PRE2,
		ST_REF1, ST_REF2, ST_MR_CLEAR, ST_DONE
	} init_state_e;
	typedef logic [3:0] cmd_t;
	typedef logic [13:0] addr_t;
endpackage

// ### wait_counter.sv
// loadable down counter used for the precharge, mode set and refresh waits
module wait_counter (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// load and status
	input wire logic load,
	input wire logic [15:0] count,
	output logic expired
);
	typedef struct packed {
		logic [15:0] cnt;
	} wait_s;
	wait_s state_q;
	wait_s state_d;

	// a load of n gives n cycles before expired rises
	always_comb begin
		state_d = state_q;
		if (load) begin
			state_d.cnt = count;
		end else if (state_q.cnt != 16'h0000) begin
			state_d.cnt = state_q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// no bypass from load: the caller's load depends on expired, so a bypass would loop
	assign expired = (state_q.cnt == 16'h0000);
endmodule

// ### read_gate.sv
// counts clocks after a dll reset and gates read commands until lock
module read_gate (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// dll reset event and gate
	input wire logic dll_reset,
	output logic reads_allowed
);
	`include "ddr_init_defs.svh"
	typedef struct packed {
		logic [7:0] cnt;
		logic armed;
	} gate_s;
	gate_s state_q;
	gate_s state_d;

	// reads stay blocked until the full lock time has passed
	always_comb begin
		state_d = state_q;
		if (dll_reset) begin
			state_d.cnt = 8'(`DLL_LOCK_CYC);
			state_d.armed = 1'b1;
		end else if (state_q.cnt != 8'h00) begin
			state_d.cnt = state_q.cnt - 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign reads_allowed = state_q.armed && (state_q.cnt == 8'h00); // RL8
endmodule

// ### ddr_init_sequencer.sv
// power-up initialization sequencer driving a ddr memory module
// Behaviour
// (RL1) cke low, clocks stable, 200us wait
// (RL2) at least one nop after raising cke
// (RL3) device cke becomes sstl input afterwards
// (RL4) precharge all, then precharge wait with nops
// (RL5) extended mode: dll enabled, drive bit, zeros
// (RL6) mode set wait after each load mode
// (RL7) base mode write with dll reset
// (RL8) 200 clocks from dll reset to read
// (RL9) second precharge all, then precharge wait
// (RL10) two refreshes, each with refresh wait
// (RL11) optional final load mode clearing dll reset
// (RL12) device accepts commands after last wait
// (RL13) frequency change needs dll reset, 200 clocks
// (RL14) waits rounded up, nops every edge
// (RL15) ready after sequence, reads blocked until lock
module ddr_init_sequencer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// software register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// read request from the memory controller core
	input wire logic read_req,
	output logic read_grant,
	// memory module command pins
	output logic mem_cke,
	output logic mem_cs_n,
	output logic mem_ras_n,
	output logic mem_cas_n,
	output logic mem_we_n,
	output ddr_init_pkg::addr_t mem_addr,
	output logic [1:0] mem_ba,
	// status
	output logic init_ready
);
	import ddr_init_pkg::*;
	`include "ddr_init_defs.svh"

	parameter int POWERUP_CYCLES = `POWERUP_WAIT_CYC;

	typedef struct packed {
		init_state_e st;
		logic issued;
		logic cke;
		cmd_t cmd;
		addr_t addr;
		logic [1:0] ba;
		logic [15:0] rdata;
		logic [3:0] ctrl;
		logic [11:0] mode;
		logic ready;
		logic [13:0] pw_cnt;
	} seq_s;
	seq_s s_q;
	seq_s s_d;

	logic wait_load;
	logic [15:0] wait_count;
	logic wait_done;
	logic dll_reset_pulse;
	logic reads_ok;

	wait_counter u_wait (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(wait_load),
		.count(wait_count),
		.expired(wait_done)
	);

	read_gate u_gate (
		.sys_clk(sys_clk),
		.rst(rst),
		.dll_reset(dll_reset_pulse),
		.reads_allowed(reads_ok)
	);

	// sequence and register file in one next-state process
	always_comb begin
		s_d = s_q;
		wait_load = 1'b0;
		wait_count = 16'h0000;
		dll_reset_pulse = 1'b0;
		s_d.cmd = `CMD_NOP; // RL14
		s_d.addr = '0;
		s_d.ba = 2'h0;
		s_d.issued = 1'b0; // blocks a repeat while the counter reloads
		s_d.rdata = 16'h0000;
		// register access
		if (reg_wr) begin
			unique case (reg_addr)
				`REG_CTRL: s_d.ctrl = reg_wdata[3:0];
				`REG_MODE: s_d.mode = reg_wdata[11:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`REG_CTRL: s_d.rdata = {12'h000, s_q.ctrl};
				`REG_MODE: s_d.rdata = {4'h0, s_q.mode};
				`REG_STATUS: s_d.rdata = {10'h000, reads_ok, s_q.ready, s_q.st};
				default: s_d.rdata = 16'h0000;
			endcase
		end
		unique case (s_q.st)
			// parked with cke low until software sets the start bit
			ST_IDLE: begin
				s_d.cke = 1'b0; // RL1
				s_d.cmd = `CMD_DESELECT;
				if (s_q.ctrl[`CTRL_START]) begin
					s_d.st = ST_POWER_WAIT;
					s_d.pw_cnt = 14'(POWERUP_CYCLES);
				end
			end
			ST_POWER_WAIT: begin
				// cke held low for the full settle time; counted in the local 14-bit pw_cnt rather than the 16-bit wait counter
				s_d.cmd = `CMD_DESELECT;
				if (s_q.pw_cnt != 14'h0000) begin
					s_d.pw_cnt = s_q.pw_cnt - 14'h0001; // RL1
				end else begin
					s_d.cke = 1'b1; // RL3
					s_d.st = ST_FIRST_NOP;
				end
			end
			// one quiet cycle with cke high before any real command
			ST_FIRST_NOP: begin
				s_d.st = ST_PRE1; // RL2
			end
			// first precharge all; the counter is idle here so it goes out at once
			ST_PRE1: begin
				if (!s_q.issued && wait_done) begin
					s_d.cmd = `CMD_PRECHARGE; // RL4
					s_d.addr[`A10_BIT] = 1'b1;
					wait_load = 1'b1;
					wait_count = 16'(`PRECHARGE_WAIT_CYC);
					s_d.issued = 1'b1;
					s_d.st = ST_EMR;
				end
			end
			// extended mode first: dll on, drive strength from control
			ST_EMR: begin
				if (wait_done && !s_q.issued) begin
					s_d.cmd = `CMD_LOAD_MODE; // RL5
					s_d.ba = `BA_EXT_MODE;
					s_d.addr[`DLL_DISABLE_BIT] = 1'b0;
					s_d.addr[`DRIVE_STRENGTH_BIT] = s_q.ctrl[`CTRL_REDUCED_DRIVE];
					wait_load = 1'b1;
					wait_count = 16'(`MODE_SET_WAIT_CYC); // RL6
					s_d.issued = 1'b1;
					s_d.st = ST_MR;
				end
			end
			// base mode with dll reset; also the re-entry point after a clock change
			ST_MR: begin
				if (wait_done && !s_q.issued) begin
					s_d.cmd = `CMD_LOAD_MODE; // RL7
					s_d.ba = `BA_BASE_MODE;
					s_d.addr = {2'h0, s_q.mode};
					s_d.addr[`DLL_RESET_BIT] = 1'b1;
					dll_reset_pulse = 1'b1; // RL13
					wait_load = 1'b1;
					wait_count = 16'(`MODE_SET_WAIT_CYC); // RL6
					s_d.issued = 1'b1;
					s_d.st = s_q.ctrl[`CTRL_REFRESH_EARLY] ? ST_REF1 : ST_PRE2;
				end
			end
			ST_PRE2: begin
				if (wait_done && !s_q.issued) begin
					s_d.cmd = `CMD_PRECHARGE; // RL9
					s_d.addr[`A10_BIT] = 1'b1;
					wait_load = 1'b1;
					wait_count = 16'(`PRECHARGE_WAIT_CYC);
					s_d.issued = 1'b1;
					// with early refresh both refreshes already ran
					s_d.st = s_q.ctrl[`CTRL_REFRESH_EARLY] ? ST_MR_CLEAR : ST_REF1;
				end
			end
			// both refreshes share one body; control bit 3 decides where they sit
			ST_REF1, ST_REF2: begin
				if (wait_done && !s_q.issued) begin
					s_d.cmd = `CMD_REFRESH; // RL10
					wait_load = 1'b1;
					wait_count = 16'(`REFRESH_CYCLE_WAIT_CYC);
					s_d.issued = 1'b1;
					if (s_q.st == ST_REF1) begin
						s_d.st = ST_REF2;
					end else begin
						s_d.st = s_q.ctrl[`CTRL_REFRESH_EARLY] ? ST_PRE2 : ST_MR_CLEAR;
					end
				end
			end
			// optional dll-clear write; when skipped the dll reset bit stays as last written
			ST_MR_CLEAR: begin
				if (wait_done && !s_q.issued) begin
					if (s_q.ctrl[`CTRL_CLEAR_DLL]) begin
						// same operating parameters, dll reset bit low
						s_d.cmd = `CMD_LOAD_MODE; // RL11
						s_d.ba = `BA_BASE_MODE;
						s_d.addr = {2'h0, s_q.mode};
						s_d.addr[`DLL_RESET_BIT] = 1'b0;
						wait_load = 1'b1;
						wait_count = 16'(`MODE_SET_WAIT_CYC); // RL6
						s_d.issued = 1'b1;
					end
					s_d.st = ST_DONE;
				end
			end
			// ready only once the last wait has run out
			ST_DONE: begin
				if (wait_done && !s_q.issued) begin
					s_d.ready = 1'b1; // RL15
				end
				// a new start request re-resets the dll, e.g. after a clock change
				if (s_q.ready && reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_START]) begin
					s_d.ready = 1'b0;
					s_d.st = ST_MR; // RL13
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '{st: ST_IDLE, issued: 1'b0, cke: 1'b0, cmd: `CMD_DESELECT, addr: '0,
				ba: 2'h0, rdata: 16'h0000, ctrl: 4'h0, mode: 12'h000, ready: 1'b0,
				pw_cnt: 14'h0000};
		end else begin
			s_q <= s_d;
		end
	end

	// command pins come straight from flip-flops
	assign mem_cke = s_q.cke;
	assign mem_cs_n = s_q.cmd[3];
	assign mem_ras_n = s_q.cmd[2];
	assign mem_cas_n = s_q.cmd[1];
	assign mem_we_n = s_q.cmd[0];
	assign mem_addr = s_q.addr;
	assign mem_ba = s_q.ba;
	assign reg_rdata = s_q.rdata;
	assign init_ready = s_q.ready; // RL12
	assign read_grant = read_req && s_q.ready && reads_ok; // RL15
endmodule

// ### ddr_init_checker.sv
// concurrent checks on the power-up sequencer ports
`include "ddr_init_defs.svh"
module ddr_init_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port and read gate
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic read_req,
	input wire logic read_grant,
	// memory pins and status
	input wire logic mem_cke,
	input wire logic mem_cs_n,
	input wire logic mem_ras_n,
	input wire logic mem_cas_n,
	input wire logic mem_we_n,
	input wire ddr_init_pkg::addr_t mem_addr,
	input wire logic [1:0] mem_ba,
	input wire logic init_ready
);
	import ddr_init_pkg::*;
	cmd_t cmd;
	logic idle;
	// decoded command and quiet flag
	assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
	assign idle = cmd == `CMD_NOP || cmd == `CMD_DESELECT;
	// cycles since the last dll-resetting base mode write, saturating; zero means none yet
	logic [8:0] lock_cnt_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lock_cnt_q <= 9'h000;
		end else if (cmd == `CMD_LOAD_MODE && mem_ba == `BA_BASE_MODE
			&& mem_addr[`DLL_RESET_BIT]) begin
			lock_cnt_q <= 9'h001;
		end else if (lock_cnt_q != 9'h000 && lock_cnt_q != 9'h1FF) begin
			lock_cnt_q <= lock_cnt_q + 9'h001;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// steps of a command followed by its quiet cycles
	sequence pre_wait; mem_addr[`A10_BIT] ##1 idle; endsequence
	sequence ref_wait; idle [*3]; endsequence
	cke_low_quiet_a: assert property (!mem_cke |-> mem_cs_n)
		else $error("command issued with cke low");
	cke_rise_nop_a: assert property ($rose(mem_cke) |-> idle)
		else $error("command on cke rise");
	cke_stays_a: assert property (mem_cke |=> mem_cke)
		else $error("cke dropped");
	precharge_all_a: assert property (cmd == `CMD_PRECHARGE |-> pre_wait)
		else $error("precharge not all banks or no wait");
	refresh_gap_a: assert property (cmd == `CMD_REFRESH |=> ref_wait)
		else $error("refresh wait too short");
	ext_mode_a: assert property (cmd == `CMD_LOAD_MODE && mem_ba == `BA_EXT_MODE |->
		!mem_addr[0] && mem_addr[13:2] == 12'h000)
		else $error("extended mode bits wrong");
	mode_gap_a: assert property (cmd == `CMD_LOAD_MODE |=> idle)
		else $error("no wait after load mode");
	grant_gate_a: assert property (read_grant |-> read_req && init_ready)
		else $error("read granted early");
	grant_lock_a: assert property (read_grant |-> lock_cnt_q >= 9'(`DLL_LOCK_CYC))
		else $error("read granted before dll lock");
	ready_cke_a: assert property (init_ready |-> mem_cke)
		else $error("ready without cke");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
endmodule

// ### ddr_device_model.sv
// behavioural memory module that polices the command stream it receives
`include "ddr_init_defs.svh"
module ddr_device_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// command pins and read grant
	input wire logic mem_cke,
	input wire logic mem_cs_n,
	input wire logic mem_ras_n,
	input wire logic mem_cas_n,
	input wire logic mem_we_n,
	input wire ddr_init_pkg::addr_t mem_addr,
	input wire logic [1:0] mem_ba,
	input wire logic read_grant,
	// observations
	output logic [7:0] errs,
	output logic [31:0] cmd_log,
	output logic drive,
	output ddr_init_pkg::addr_t mode
);
	import ddr_init_pkg::*;
	parameter int POWERUP_CYCLES = 20;
	int low_cnt, gap, need, since_dll;
	logic woke;
	cmd_t cmd;
	assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
	// every edge: count waits, log commands, flag what a real part would mis-take
	always @(posedge sys_clk) begin
		if (rst) begin
			errs = 8'h00; cmd_log = 32'h0000_0000; drive = 1'b0; mode = 14'h0000;
			low_cnt = 0; gap = 0; need = 0; since_dll = 1000; woke = 1'b0;
		end else begin
			gap++;
			since_dll++;
			if (!mem_cke) begin
				low_cnt++;
				if (woke || !mem_cs_n) errs++;
			end else begin
				if (!woke && low_cnt < POWERUP_CYCLES) errs++;
				if (cmd == `CMD_NOP || cmd == `CMD_DESELECT) woke = 1'b1;
				else begin
					// a wait of n cycles means n quiet cycles between two commands
					if (!woke || gap <= need) errs++;
					cmd_log = {cmd_log[27:0], cmd};
					gap = 0;
					case (cmd)
						`CMD_PRECHARGE: begin
							need = `PRECHARGE_WAIT_CYC;
							if (!mem_addr[`A10_BIT]) errs++;
						end
						`CMD_REFRESH: need = `REFRESH_CYCLE_WAIT_CYC;
						`CMD_LOAD_MODE: begin
							need = `MODE_SET_WAIT_CYC;
							if (mem_ba == `BA_EXT_MODE) begin
								drive = mem_addr[1];
								if (mem_addr[0] || mem_addr[13:2] != 12'h000) errs++;
							end else if (mem_addr[`DLL_RESET_BIT]) begin
								since_dll = 0;
								mode = mem_addr & 14'h3EFF;
							end else if (mem_addr != mode) errs++;
						end
						// after the last wait any command is taken; none other is expected here
						default: errs++;
					endcase
				end
			end
			if (read_grant && since_dll < `DLL_LOCK_CYC) errs++;
		end
	end
endmodule

// ### ddr_init_sequencer_tb.sv
// self-checking bench for the power-up sequencer
`include "ddr_init_defs.svh"
module ddr_init_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ddr_init_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, read_req = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic read_grant, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, init_ready, drive;
	addr_t mem_addr, mode;
	logic [1:0] mem_ba;
	logic [7:0] errs;
	logic [31:0] cmd_log;
	int bad_count = 0, comparisons = 0, cycles = 0;
	always #12.5 sys_clk = ~sys_clk;
	ddr_init_sequencer #(.POWERUP_CYCLES(20)) u_ddr_init_sequencer (.sys_clk(sys_clk),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .read_req(read_req), .read_grant(read_grant),
		.mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
		.mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_ba(mem_ba), .init_ready(init_ready));
	ddr_device_model #(.POWERUP_CYCLES(20)) u_ddr_device_model (.sys_clk(sys_clk), .rst(rst),
		.mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
		.mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_ba(mem_ba), .read_grant(read_grant),
		.errs(errs), .cmd_log(cmd_log), .drive(drive), .mode(mode));
	task check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task results;
		if (bad_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task reg_write(logic [3:0] a, logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task reg_read(logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task do_reset;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
	endtask
	// bounded wait on ready (sel 0) or grant (sel 1), sampled after the edge settles
	task wait_high(string what, bit sel);
		int n;
		n = 0;
		while ((sel ? read_grant : init_ready) !== 1'b1 && n < 1000) begin
			@(posedge sys_clk);
			#1 n++;
		end
		check(what, 1, sel ? read_grant : init_ready);
	endtask
	task t_reset_state;
		logic [15:0] d;
		do_reset;
		@(posedge sys_clk);
		#1 check("cke", 0, mem_cke);
		check("ready", 0, init_ready);
		reg_read(4'h9, d);
		check("unmapped", 0, d);
	endtask
	task t_full_init;
		logic [15:0] d;
		int n;
		reg_write(`REG_MODE, 16'h0032);
		reg_write(`REG_CTRL, 16'h0007);
		n = 0;
		while (mem_cke !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1 n++;
		end
		check("powerup", 22, n);
		wait_high("ready", 1'b0);
		check("order", 32'h0200_2110, cmd_log);
		check("device", 0, errs);
		check("drive", 1, drive);
		check("mode", 32'h0032, mode);
		@(posedge sys_clk);
		read_req <= 1'b1;
		@(posedge sys_clk);
		#1 check("grant", 0, read_grant);
		reg_read(`REG_STATUS, d);
		check("status", 1, d[4]);
		check("locked", 0, d[5]);
		reg_read(`REG_MODE, d);
		check("mode reg", 16'h0032, d);
	endtask
	task t_read_gate;
		@(posedge sys_clk);
		read_req <= 1'b1;
		wait_high("grant", 1'b1);
		@(posedge sys_clk);
		#1 check("device", 0, errs);
	endtask
	task t_rerun;
		reg_write(`REG_CTRL, 16'h0001);
		repeat (3) @(posedge sys_clk);
		#1 check("grant", 0, read_grant);
		wait_high("grant", 1'b1);
		@(posedge sys_clk);
		read_req <= 1'b0;
		#1 check("device", 0, errs);
	endtask
	task t_early_refresh;
		do_reset;
		reg_write(`REG_MODE, 16'h0021);
		reg_write(`REG_CTRL, 16'h0009);
		wait_high("ready", 1'b0);
		check("order", 32'h0020_0112, cmd_log);
		check("drive", 0, drive);
		check("device", 0, errs);
	endtask
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			results;
		end
	end
	initial begin
		t_reset_state;
		t_full_init;
		t_read_gate;
		t_rerun;
		t_early_refresh;
		results;
	end
endmodule
bind ddr_init_sequencer ddr_init_checker u_ddr_init_checker (.sys_clk(sys_clk), .rst(rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .read_req(read_req), .read_grant(read_grant),
	.mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
	.mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_ba(mem_ba), .init_ready(init_ready));
